/* File: core/hcmd_pkg.sv */
// shared constants and rate arithmetic for the host command link
// assumes a 50 mhz system clock on both ends and 8n1 serial framing
package hcmd_pkg;
  // ==========================================
  // clock and line rate
  localparam int CLK_KHZ = 50000;
  localparam int CARRIER_KHZ = 13560;
  localparam logic [7:0] RESET_DIVISOR = 8'h75;
  localparam logic [7:0] MIN_DIVISOR = 8'h02;
  localparam logic [3:0] RX_LAST_BIT = 4'h9;
  localparam logic [3:0] TX_LAST_BIT = 4'h9;
  // ==========================================
  // command codes and frame values
  localparam logic [7:0] CMD_SELECT = 8'h02;
  localparam logic [7:0] CMD_WRITE = 8'h09;
  localparam logic [7:0] CMD_RATE = 8'h0a;
  localparam logic [7:0] CMD_ECHO = 8'h55;
  localparam logic [7:0] LEN_WR_SHORT = 8'h03;
  localparam logic [7:0] LEN_WR_LONG = 8'h04;
  localparam logic [7:0] LEN_RATE = 8'h01;
  localparam logic [7:0] FLAG_NO_INC = 8'h00;
  localparam logic [7:0] FLAG_INC = 8'h01;
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_ERR = 8'h82;
  localparam logic [7:0] RATE_ACK = 8'h55;
  localparam logic [8:0] STORE_BYTES = 9'h004;
  // ==========================================
  // device registers
  localparam logic [7:0] IDX_TIMING = 8'h3a;
  localparam logic [7:0] IDX_FILTER = 8'h0d;
  localparam logic [7:0] TW_DEFAULT = 8'h52;
  localparam logic [7:0] TW_MIN = 8'h50;
  localparam logic [7:0] TW_MAX = 8'h60;
  localparam logic [7:0] TW_CONFIRM = 8'h04;
  // ==========================================
  // host controller registers
  localparam logic [1:0] ADDR_TX = 2'h0;
  localparam logic [1:0] ADDR_RX = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_DIV = 2'h3;
  localparam int STAT_TX_BUSY = 0;
  localparam int STAT_RX_READY = 1;
  localparam int STAT_RX_ERR = 2;
  localparam int STAT_DIV_PEND = 3;

  // clock cycles per bit for a divisor: clock * (2d+2) / carrier, rounded down
  function automatic logic [15:0] bit_cycles(input logic [7:0] d);
    logic [31:0] t;
    t = (CLK_KHZ * (32'(d) * 32'd2 + 32'd2)) / CARRIER_KHZ;
    return t[15:0];
  endfunction
endpackage

/* File: core/hcmd_link_if.sv */
// serial link between host controller and command device
// assumes both ends run on the same system clock; lines idle high
`timescale 1ns/1ps
interface hcmd_link_if;
  logic host_to_dev;
  logic dev_to_host;
  modport dev(input host_to_dev, output dev_to_host);
  modport host(output host_to_dev, input dev_to_host);
endinterface

/* File: core/hcmd_device.sv */
// command device end: serial receiver, command interpreter, serial sender
// assumes the host keeps to the frame formats; link is half duplex
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - timing window kept within 0x50..0x60
// - protocol select reloads timing window default
// - host suggests 0x56 or 0x58
// - window write: code, length, index, data
// - flag byte: zero no increment, one increment
// - window write ends with confirmation byte
// - protocol select disables sync filter
// - rate command: code, length one, divisor
// - bit rate is carrier over 2d+2
// - divisor 117 after reset
// - divisors zero and one are refused
// - rate acknowledge sent at new rate
// - failed rate command keeps old rate
// - echo byte answered with same byte
// - good register write answers zero, zero
module hcmd_device
  import hcmd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  hcmd_link_if.dev link,
  output logic [7:0] timing_window_out,
  output logic sync_filter_out,
  output logic [7:0] rate_divisor_out
);
  typedef enum logic [2:0] {
    S_CMD = 3'b000,
    S_LEN = 3'b001,
    S_DATA = 3'b010,
    S_EXEC = 3'b011,
    S_REPLY = 3'b100
  } dev_state_t;

  logic [7:0] divisor;
  logic [15:0] bitc;
  assign bitc = bit_cycles(divisor);

  // ==========================================
  // receiver
  logic rx_s1, rx_s2;
  logic rx_busy, next_rx_busy;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [3:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  logic rx_done, next_rx_done;
  logic [15:0] rx_target;

  always_comb begin
    next_rx_busy = rx_busy;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    next_rx_done = 1'b0;
    rx_target = (rx_bit == '0) ? (bitc >> 1) : bitc;
    if (!rx_busy) begin
      if (!rx_s2) begin
        next_rx_busy = 1'b1;
        next_rx_cnt = '0;
        next_rx_bit = '0;
      end
    end else if (rx_cnt == rx_target - 16'h0001) begin
      next_rx_cnt = '0;
      next_rx_bit = rx_bit + 4'h1;
      if (rx_bit == '0) begin
        // a start bit gone high by mid-bit was a glitch
        next_rx_busy = !rx_s2;
      end else if (rx_bit == RX_LAST_BIT) begin
        next_rx_busy = 1'b0;
        next_rx_done = rx_s2;
      end else begin
        next_rx_sh = {rx_s2, rx_sh[7:1]};
      end
    end else begin
      next_rx_cnt = rx_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_busy <= 1'b0;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
      rx_done <= 1'b0;
    end else begin
      rx_s1 <= link.host_to_dev;
      rx_s2 <= rx_s1;
      rx_busy <= next_rx_busy;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
      rx_done <= next_rx_done;
    end
  end

  // ==========================================
  // sender
  logic tx_go;
  logic [7:0] tx_byte;
  logic tx_busy, next_tx_busy;
  logic tx_line, next_tx_line;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_bit, next_tx_bit;
  logic [8:0] tx_sh, next_tx_sh;

  always_comb begin
    next_tx_busy = tx_busy;
    next_tx_line = tx_line;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_sh = tx_sh;
    if (tx_go) begin
      next_tx_busy = 1'b1;
      next_tx_line = 1'b0;
      next_tx_cnt = '0;
      next_tx_bit = '0;
      next_tx_sh = {1'b1, tx_byte};
    end else if (tx_busy) begin
      if (tx_cnt == bitc - 16'h0001) begin
        next_tx_cnt = '0;
        if (tx_bit == TX_LAST_BIT) begin
          next_tx_busy = 1'b0;
        end else begin
          next_tx_line = tx_sh[0];
          next_tx_sh = {1'b1, tx_sh[8:1]};
          next_tx_bit = tx_bit + 4'h1;
        end
      end else begin
        next_tx_cnt = tx_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      tx_cnt <= '0;
      tx_bit <= '0;
      tx_sh <= '1;
    end else begin
      tx_busy <= next_tx_busy;
      tx_line <= next_tx_line;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_sh <= next_tx_sh;
    end
  end
  assign link.dev_to_host = tx_line;

  // ==========================================
  // command interpreter
  dev_state_t state, next_state;
  logic [7:0] cmd, next_cmd;
  logic [7:0] len, next_len;
  logic [8:0] cnt, next_cnt;
  logic [3:0][7:0] store, next_store;
  logic [1:0][7:0] resp, next_resp;
  logic resp_two, next_resp_two;
  logic resp_i, next_resp_i;
  logic [7:0] timing_window, next_timing_window;
  logic sync_filter, next_sync_filter;
  logic [7:0] next_divisor;
  logic next_tx_go;
  logic [7:0] next_tx_byte;
  logic wr_ok;

  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_len = len;
    next_cnt = cnt;
    next_store = store;
    next_resp = resp;
    next_resp_two = resp_two;
    next_resp_i = resp_i;
    next_timing_window = timing_window;
    next_sync_filter = sync_filter;
    next_divisor = divisor;
    next_tx_go = 1'b0;
    next_tx_byte = tx_byte;
    wr_ok = (len == LEN_WR_SHORT || len == LEN_WR_LONG) && store[1] <= FLAG_INC;
    case (state)
      S_CMD: begin
        if (rx_done) begin
          next_cmd = rx_sh;
          next_state = (rx_sh == CMD_ECHO) ? S_EXEC : S_LEN;
        end
      end
      S_LEN: begin
        if (rx_done) begin
          next_len = rx_sh;
          next_cnt = '0;
          next_state = (rx_sh == '0) ? S_EXEC : S_DATA;
        end
      end
      S_DATA: begin
        if (rx_done) begin
          // bytes beyond the store are drained, not kept
          if (cnt < STORE_BYTES) begin
            next_store[cnt[1:0]] = rx_sh;
          end
          next_cnt = cnt + 9'h001;
          if (next_cnt == {1'b0, len}) begin
            next_state = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        next_resp = {RES_OK, RES_ERR};
        next_resp_two = 1'b1;
        next_resp_i = 1'b0;
        next_state = S_REPLY;
        case (cmd)
          CMD_ECHO: begin
            next_resp[0] = CMD_ECHO;
            next_resp_two = 1'b0;
          end
          CMD_SELECT: begin
            next_timing_window = TW_DEFAULT;
            next_sync_filter = 1'b0;
            next_resp = {RES_OK, RES_OK};
          end
          CMD_WRITE: begin
            if (wr_ok && store[0] == IDX_TIMING && len == LEN_WR_LONG &&
                store[3] == TW_CONFIRM && store[2] >= TW_MIN && store[2] <= TW_MAX) begin
              next_timing_window = store[2];
              next_resp = {RES_OK, RES_OK};
            end else if (wr_ok && store[0] == IDX_FILTER) begin
              next_sync_filter = store[2][0];
              next_resp = {RES_OK, RES_OK};
            end
          end
          CMD_RATE: begin
            // a refused divisor answers at the old rate
            if (len == LEN_RATE && store[0] >= MIN_DIVISOR) begin
              next_divisor = store[0];
              next_resp[0] = RATE_ACK;
              next_resp_two = 1'b0;
            end
          end
          default: begin
            next_resp = {RES_OK, RES_ERR};
          end
        endcase
      end
      S_REPLY: begin
        // divisor already updated, so the ack leaves at the new rate
        if (!tx_busy && !tx_go) begin
          next_tx_go = 1'b1;
          next_tx_byte = resp[resp_i];
          next_resp_i = 1'b1;
          if (resp_i || !resp_two) begin
            next_state = S_CMD;
          end
        end
      end
      default: begin
        next_state = S_CMD;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      state <= S_CMD;
      cmd <= '0;
      len <= '0;
      cnt <= '0;
      store <= '0;
      resp <= '0;
      resp_two <= 1'b0;
      resp_i <= 1'b0;
      timing_window <= TW_DEFAULT;
      sync_filter <= 1'b0;
      divisor <= RESET_DIVISOR;
      tx_go <= 1'b0;
      tx_byte <= '0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      len <= next_len;
      cnt <= next_cnt;
      store <= next_store;
      resp <= next_resp;
      resp_two <= next_resp_two;
      resp_i <= next_resp_i;
      timing_window <= next_timing_window;
      sync_filter <= next_sync_filter;
      divisor <= next_divisor;
      tx_go <= next_tx_go;
      tx_byte <= next_tx_byte;
    end
  end

  assign timing_window_out = timing_window;
  assign sync_filter_out = sync_filter;
  assign rate_divisor_out = divisor;
endmodule

/* File: core/hcmd_host.sv */
// host controller end: software register port driving the serial link
// assumes software polls status; one byte in flight each way
`timescale 1ns/1ps
module hcmd_host
  import hcmd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  hcmd_link_if.host link,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out
);
  logic [7:0] divisor;
  logic [15:0] bitc;
  assign bitc = bit_cycles(divisor);

  // ==========================================
  // receiver
  logic rx_s1, rx_s2;
  logic rx_busy, next_rx_busy;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [3:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  logic rx_done, rx_bad;
  logic [15:0] rx_target;

  always_comb begin
    next_rx_busy = rx_busy;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    rx_done = 1'b0;
    rx_bad = 1'b0;
    rx_target = (rx_bit == '0) ? (bitc >> 1) : bitc;
    if (!rx_busy) begin
      if (!rx_s2) begin
        next_rx_busy = 1'b1;
        next_rx_cnt = '0;
        next_rx_bit = '0;
      end
    end else if (rx_cnt == rx_target - 16'h0001) begin
      next_rx_cnt = '0;
      next_rx_bit = rx_bit + 4'h1;
      if (rx_bit == '0) begin
        next_rx_busy = !rx_s2;
      end else if (rx_bit == RX_LAST_BIT) begin
        next_rx_busy = 1'b0;
        rx_done = rx_s2;
        rx_bad = !rx_s2;
      end else begin
        next_rx_sh = {rx_s2, rx_sh[7:1]};
      end
    end else begin
      next_rx_cnt = rx_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_busy <= 1'b0;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
    end else begin
      rx_s1 <= link.dev_to_host;
      rx_s2 <= rx_s1;
      rx_busy <= next_rx_busy;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
    end
  end

  // ==========================================
  // sender and software registers
  logic tx_busy, next_tx_busy;
  logic tx_line, next_tx_line;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_bit, next_tx_bit;
  logic [8:0] tx_sh, next_tx_sh;
  logic [7:0] next_divisor;
  logic [7:0] div_pend, next_div_pend;
  logic pend, next_pend;
  logic [7:0] rx_data, next_rx_data;
  logic rx_ready, next_rx_ready;
  logic rx_err, next_rx_err;
  logic [7:0] next_rdata;

  always_comb begin
    next_tx_busy = tx_busy;
    next_tx_line = tx_line;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_sh = tx_sh;
    next_divisor = divisor;
    next_div_pend = div_pend;
    next_pend = pend;
    next_rx_data = rx_data;
    next_rx_ready = rx_ready;
    next_rx_err = rx_err;
    next_rdata = '0;
    if (tx_busy) begin
      if (pend && tx_bit == TX_LAST_BIT && tx_cnt == (bitc >> 1)) begin
        // far end answers from its mid-stop sample at the new rate, so the
        // switch cannot wait out the stop bit; the line simply stays high
        next_tx_busy = 1'b0;
        next_tx_cnt = '0;
        next_divisor = div_pend;
        next_pend = 1'b0;
      end else if (tx_cnt == bitc - 16'h0001) begin
        next_tx_cnt = '0;
        if (tx_bit == TX_LAST_BIT) begin
          next_tx_busy = 1'b0;
        end else begin
          next_tx_line = tx_sh[0];
          next_tx_sh = {1'b1, tx_sh[8:1]};
          next_tx_bit = tx_bit + 4'h1;
        end
      end else begin
        next_tx_cnt = tx_cnt + 16'h0001;
      end
    end else if (pend) begin
      // with no byte on the line, the new rate applies at once
      next_divisor = div_pend;
      next_pend = 1'b0;
    end else if (wr_in && addr_in == ADDR_TX) begin
      next_tx_busy = 1'b1;
      next_tx_line = 1'b0;
      next_tx_cnt = '0;
      next_tx_bit = '0;
      next_tx_sh = {1'b1, wdata_in};
    end
    if (wr_in && addr_in == ADDR_DIV && wdata_in >= MIN_DIVISOR) begin
      next_div_pend = wdata_in;
      next_pend = 1'b1;
    end
    if (rd_in && addr_in == ADDR_RX) begin
      next_rx_ready = 1'b0;
      next_rx_err = 1'b0;
      next_rdata = rx_data;
    end
    if (rd_in && addr_in == ADDR_STATUS) begin
      next_rdata[STAT_TX_BUSY] = tx_busy;
      next_rdata[STAT_RX_READY] = rx_ready;
      next_rdata[STAT_RX_ERR] = rx_err;
      next_rdata[STAT_DIV_PEND] = pend;
    end
    if (rd_in && addr_in == ADDR_DIV) begin
      next_rdata = divisor;
    end
    // arrival wins over a clear in the same cycle
    if (rx_done) begin
      next_rx_data = rx_sh;
      next_rx_ready = 1'b1;
    end
    if (rx_bad) begin
      next_rx_err = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      tx_cnt <= '0;
      tx_bit <= '0;
      tx_sh <= '1;
      divisor <= RESET_DIVISOR;
      div_pend <= RESET_DIVISOR;
      pend <= 1'b0;
      rx_data <= '0;
      rx_ready <= 1'b0;
      rx_err <= 1'b0;
      rdata_out <= '0;
    end else begin
      tx_busy <= next_tx_busy;
      tx_line <= next_tx_line;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_sh <= next_tx_sh;
      divisor <= next_divisor;
      div_pend <= next_div_pend;
      pend <= next_pend;
      rx_data <= next_rx_data;
      rx_ready <= next_rx_ready;
      rx_err <= next_rx_err;
      rdata_out <= next_rdata;
    end
  end
  assign link.host_to_dev = tx_line;
endmodule

/* File: verification/hcmd_props.sv */
// concurrent checks on the host command link and the device outputs
// assumes the bench top instantiates it beside the link interface
`timescale 1ns/1ps
module hcmd_props (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic host_to_dev,
  input wire logic dev_to_host,
  input wire logic [7:0] timing_window_out,
  input wire logic sync_filter_out,
  input wire logic [7:0] rate_divisor_out
);
  // ==========================================
  // sequences
  default clocking cb @(posedge clk_sys_in); endclocking
  // reply start is a few cycles after the frame is taken
  sequence ack_start;
    ##[1:8] $fell(dev_to_host);
  endsequence
  // divisor 2 gives 22 cycles a bit
  sequence fast_start_bit;
    ##21 !dev_to_host ##1 dev_to_host;
  endsequence
  // ==========================================
  // assertions
  a_tw_in_range: assert property (disable iff (!reset_n_in)
    timing_window_out >= 8'h50 && timing_window_out <= 8'h60)
    else $error("timing window left its range");
  a_tw_reset: assert property (!reset_n_in |=> timing_window_out == 8'h52)
    else $error("timing window not at default after reset");
  a_filter_reset: assert property (!reset_n_in |=> !sync_filter_out)
    else $error("sync filter enabled after reset");
  a_div_reset: assert property (!reset_n_in |=> rate_divisor_out == 8'h75)
    else $error("divisor not at power-up value");
  a_div_min: assert property (disable iff (!reset_n_in) rate_divisor_out >= 8'h02)
    else $error("reserved divisor in use");
  a_div_quiet: assert property (disable iff (!reset_n_in)
    $changed(rate_divisor_out) |-> host_to_dev && dev_to_host)
    else $error("divisor changed inside a byte");
  a_tw_quiet: assert property (disable iff (!reset_n_in)
    $changed(timing_window_out) || $changed(sync_filter_out) |-> host_to_dev)
    else $error("register changed before the frame ended");
  a_ack_rate: assert property (disable iff (!reset_n_in)
    $changed(rate_divisor_out) && rate_divisor_out == 8'h02 |-> ack_start ##0 fast_start_bit)
    else $error("rate ack not sent at new rate");
  a_reply_idle: assert property (disable iff (!reset_n_in)
    $fell(dev_to_host) |-> host_to_dev && $past(host_to_dev))
    else $error("reply started while host was sending");
  a_lines_idle: assert property (!reset_n_in |=> host_to_dev && dev_to_host)
    else $error("line not idle high after reset");
endmodule

/* File: verification/tb_top.sv */
// self-checking bench: host controller and device joined by the link interface
// assumes software-style polling of host status; one frame in flight at a time
`timescale 1ns/1ps
module tb_top;
  import hcmd_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic [7:0] timing_window_out;
  logic sync_filter_out;
  logic [7:0] rate_divisor_out;
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h0000a4d7;
  logic [7:0] v = 8'h00;
  logic [7:0] tw_exp = 8'h52;
  localparam logic [15:0] BAD_TW [3] = '{16'h4f00, 16'h6101, 16'h5602};
  always #10 clk_sys_in = ~clk_sys_in;
  hcmd_link_if link();
  hcmd_device u_hcmd_device(.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .link(link),
    .timing_window_out(timing_window_out), .sync_filter_out(sync_filter_out),
    .rate_divisor_out(rate_divisor_out));
  hcmd_host u_hcmd_host(.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .link(link),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out));
  hcmd_props u_hcmd_props(.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .host_to_dev(link.host_to_dev), .dev_to_host(link.dev_to_host),
    .timing_window_out(timing_window_out), .sync_filter_out(sync_filter_out),
    .rate_divisor_out(rate_divisor_out));
  // ==========================================
  // expectation helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // rounded down, as the bit counter can only hold whole cycles
  function automatic int exp_bitc(input int d);
    return (50000 * (2 * d + 2)) / 13560;
  endfunction
  // ==========================================
  // reporting
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic give_up(input string what);
    miscompares++;
    $display("MISMATCH t=%0t timeout waiting for %s", $time, what);
    end_sim();
  endtask
  // ==========================================
  // register port
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // ==========================================
  // link traffic through the host
  task automatic wait_tx_idle();
    logic [7:0] st;
    int n;
    n = 0;
    st = 8'hff;
    while ((st[STAT_TX_BUSY] !== 1'b0 || st[STAT_DIV_PEND] !== 1'b0) && n < 20000) begin
      reg_rd(ADDR_STATUS, st);
      n++;
    end
    if (n >= 20000) give_up("tx idle");
  endtask
  task automatic send_byte(input logic [7:0] b);
    wait_tx_idle();
    reg_wr(ADDR_TX, b);
  endtask
  task automatic send_frame(input int cnt, input logic [47:0] bytes);
    for (int i = 0; i < cnt; i++) begin
      send_byte(bytes[47 - 8 * i -: 8]);
    end
  endtask
  task automatic recv_byte(input logic [7:0] exp, input string what);
    logic [7:0] st;
    logic [7:0] d;
    int n;
    n = 0;
    st = 8'h00;
    while (st[STAT_RX_READY] !== 1'b1 && n < 20000) begin
      reg_rd(ADDR_STATUS, st);
      n++;
    end
    if (n >= 20000) give_up(what);
    reg_rd(ADDR_RX, d);
    check8(d, exp, what);
  endtask
  task automatic reply(input logic [7:0] r0, input logic [7:0] r1);
    recv_byte(r0, "result");
    recv_byte(r1, "length");
  endtask
  // samples one device byte straight off the wire, mid-bit
  task automatic watch_dev(input int bc, input logic [7:0] exp);
    logic [7:0] d;
    int n;
    n = 0;
    while (link.dev_to_host !== 1'b0 && n < 20000) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 20000) give_up("reply start");
    repeat (bc / 2) @(negedge clk_sys_in);
    check8({7'h00, link.dev_to_host}, 8'h00, "start bit");
    for (int i = 0; i < 8; i++) begin
      repeat (bc) @(negedge clk_sys_in);
      d[i] = link.dev_to_host;
    end
    repeat (bc) @(negedge clk_sys_in);
    check8({7'h00, link.dev_to_host}, 8'h01, "stop bit");
    check8(d, exp, "wire byte");
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    check8(timing_window_out, 8'h52, "tw reset");
    check8({7'h00, sync_filter_out}, 8'h00, "filter reset");
    check8(rate_divisor_out, 8'h75, "div reset");
    reg_rd(ADDR_DIV, v);
    check8(v, 8'h75, "host div reset");
    // one slow frame only: every later frame runs at the fastest divisor
    send_frame(3, {CMD_RATE, LEN_RATE, 8'h02, 24'h0});
    reg_wr(ADDR_DIV, 8'h02);
    fork
      watch_dev(exp_bitc(2), RATE_ACK);
      recv_byte(RATE_ACK, "rate ack");
    join
    check8(rate_divisor_out, 8'h02, "div new");
    for (int k = 0; k < 2; k++) begin
      send_frame(3, {CMD_RATE, LEN_RATE, 8'(k), 24'h0});
      reply(RES_ERR, 8'h00);
      check8(rate_divisor_out, 8'h02, "div kept");
    end
    reg_wr(ADDR_DIV, 8'h01);
    reg_rd(ADDR_DIV, v);
    check8(v, 8'h02, "host div refuse");
    send_byte(CMD_ECHO);
    fork
      watch_dev(exp_bitc(2), CMD_ECHO);
      recv_byte(CMD_ECHO, "echo");
    join
    for (int k = 0; k < 6; k++) begin
      seed = xorshift(seed);
      v = (k == 0) ? 8'h50 : (k == 1) ? 8'h60 : (k == 2) ? 8'h56 : (k == 3) ? 8'h58 :
        8'h50 + 8'(seed[7:0] % 17);
      send_frame(5, {CMD_WRITE, LEN_WR_LONG, IDX_TIMING, 7'h00, seed[8], v, 8'h00});
      wait_tx_idle();
      check8(timing_window_out, tw_exp, "tw early");
      send_byte(TW_CONFIRM);
      reply(RES_OK, 8'h00);
      tw_exp = v;
      check8(timing_window_out, tw_exp, "tw written");
    end
    for (int k = 0; k < 3; k++) begin
      send_frame(6, {CMD_WRITE, LEN_WR_LONG, IDX_TIMING, BAD_TW[k][7:0], BAD_TW[k][15:8],
        TW_CONFIRM});
      reply(RES_ERR, 8'h00);
      check8(timing_window_out, tw_exp, "tw refused");
    end
    send_frame(5, {CMD_WRITE, LEN_WR_SHORT, IDX_FILTER, FLAG_NO_INC, 8'h01, 8'h00});
    reply(RES_OK, 8'h00);
    check8({7'h00, sync_filter_out}, 8'h01, "filter on");
    send_frame(2, {CMD_SELECT, 8'h00, 32'h0});
    reply(RES_OK, 8'h00);
    check8(timing_window_out, 8'h52, "tw default");
    check8({7'h00, sync_filter_out}, 8'h00, "filter off");
    end_sim();
  end
endmodule
